// file: rtl/pclp_pkg.sv
// Constants, field layouts and carrier types for the PC card lane and pin control block.
// Assumes one 20 MHz bus clock and a register port driven by the bus state controller.
// What this block does
// - Area-5 second strobe floats while select cleared.
// - Area-6 strobe pin floats while select cleared.
// - Zero wait setting disables external wait input.
// - Lanes 23..16 float unless port enabled.
// - Lanes 31..24 float; port enabled drives 31,30.
package pclp_pkg;

  // Register byte addresses as the bus state controller decodes them.
  localparam logic [31:0] BUS_CONTROL_ONE_ADDR        = 32'h0fff_ff60;
  localparam logic [31:0] BUS_CONTROL_TWO_ADDR        = 32'hffff_ff62;
  localparam logic [31:0] WAIT_STATE_CONTROL_TWO_ADDR = 32'hffff_ff66;
  localparam logic [31:0] PORT_CONTROL_REG_ADDR       = 32'hffff_ff76;
  localparam logic [31:0] PORT_DATA_REG_ADDR          = 32'hffff_ff78;

  // Values after reset.
  localparam logic [15:0] BUS_CONTROL_ONE_RST        = 16'h0000;
  localparam logic [15:0] BUS_CONTROL_TWO_RST        = 16'h0000;
  localparam logic [15:0] WAIT_STATE_CONTROL_TWO_RST = 16'h0000;
  localparam logic [15:0] PORT_CONTROL_REG_RST       = 16'h0000;
  localparam logic [7:0]  PORT_DATA_REG_RST          = 8'h00;

  // Field positions.
  localparam int AREA6_CARD_SELECT_BIT   = 0;  // bus_control_one
  localparam int AREA5_CARD_SELECT_BIT   = 1;  // bus_control_one
  localparam int UPPER_LANE_PORT_EN_BIT  = 0;  // bus_control_two
  localparam int AREA5_WIDTH16_BIT       = 1;  // bus_control_two
  localparam int AREA6_WIDTH16_BIT       = 2;  // bus_control_two
  localparam int AREA5_WAIT_LSB          = 0;  // wait_state_control_two, 3 bits
  localparam int AREA6_WAIT_LSB          = 4;  // wait_state_control_two, 3 bits
  localparam int WAIT_W                  = 3;
  localparam int TOP_LANE_VALUE_LSB      = 14; // port_control_reg, values for lines 31,30

  // Access sizes, coded as the requester presents them.
  localparam logic [1:0] SIZE_BYTE = 2'h0;
  localparam logic [1:0] SIZE_WORD = 2'h1;
  localparam logic [1:0] SIZE_LONG = 2'h2;

  // Register port access widths in bits.
  localparam logic [1:0] REG_SIZE_8  = 2'h0;
  localparam logic [1:0] REG_SIZE_16 = 2'h1;

  typedef enum logic [1:0] {PCLP_IDLE, PCLP_STROBE, PCLP_GAP} pclp_state_t;

  // One card access request.
  typedef struct packed {
    logic        area6;
    logic        write;
    logic [1:0]  size;
    logic        addr0;
    logic [15:0] wdata;
  } pclp_req_t;

  // Drive of the 32 data lines.
  typedef struct packed {
    logic [31:0] out;
    logic [31:0] oe;
  } pclp_lanes_t;

endpackage : pclp_pkg

// file: rtl/pclp_lane_steer.sv
// Byte steering of the lower 16 data lines for one card bus cycle.
// Assumes the caller registers the result; purely combinational.
module pclp_lane_steer
  import pclp_pkg::*;
(
  // Cycle description.
  input  wire logic        is16,
  input  wire logic        phase,
  input  wire pclp_req_t   req,
  // Lower lane drive.
  output logic [15:0] laneOut,
  output logic [15:0] laneOe
);

  logic [7:0] oneByte;

  // On a narrow bus a word goes out as the even byte first, then the odd byte.
  always_comb begin
    oneByte = phase ? req.wdata[7:0] : req.wdata[15:8];
    if (req.size == SIZE_BYTE) begin
      oneByte = req.wdata[7:0];
    end
    laneOut = 16'h0000;
    laneOe  = 16'h0000;
    if (req.write) begin
      if (!is16) begin
        laneOut = {8'h00, oneByte};
        laneOe  = 16'h00ff;
      end else if (req.size == SIZE_BYTE) begin
        // The idle half carries a copy; the card ignores it.
        laneOut = {oneByte, oneByte};
        laneOe  = 16'hffff;
      end else begin
        laneOut = req.wdata;
        laneOe  = 16'hffff;
      end
    end
  end

endmodule // pclp_lane_steer

// file: rtl/pclp_card_ctrl.sv
// Data lane and pin state control for PC card accesses in areas 5 and 6.
// Assumes the bus state controller issues one access at a time and drives the
// register port with the access width of each register.
module pclp_card_ctrl
  import pclp_pkg::*;
(
  // Clock and reset.
  input  wire logic        clk,
  input  wire logic        rst,
  // Register port.
  input  wire logic        regWrite,
  input  wire logic        regRead,
  input  wire logic [31:0] regAddr,
  input  wire logic [1:0]  regSize,
  input  wire logic [15:0] regWdata,
  output logic [15:0] regRdata,
  output logic        regAck,
  // Card access request and answer.
  input  wire logic        accStart,
  input  wire pclp_req_t   accReq,
  output logic [15:0] accRdata,
  output logic        accDone,
  // Card pins.
  input  wire logic [31:0] dataIn,
  output pclp_lanes_t lanes,
  input  wire logic        cardWaitN,
  output logic        waitEnable,
  output logic        area5StrobeOut,
  output logic        area5StrobeOe,
  output logic        area6StrobeOut,
  output logic        area6StrobeOe
);

  typedef struct packed {
    logic [15:0] busControlOne;
    logic [15:0] busControlTwo;
    logic [15:0] waitStateControlTwo;
    logic [15:0] portControlReg;
    logic [7:0]  portData;
    pclp_state_t st;
    logic [WAIT_W-1:0] cnt;
    logic        phase;
    pclp_req_t   req;
    logic [15:0] rdata;
    logic        done;
    logic [15:0] regRdata;
    logic        regAck;
    pclp_lanes_t lanes;
    logic        waitEnable;
    logic        s5Out;
    logic        s5Oe;
    logic        s6Out;
    logic        s6Oe;
  } pclp_regs_t;

  pclp_regs_t state_r;
  pclp_regs_t state_nxt;

  logic [15:0] steerOut;
  logic [15:0] steerOe;
  logic        curIs16;
  logic        startNow;
  pclp_req_t   nxtReq;
  logic        nxtPhase;
  logic        nxtIs16;
  logic        nxtSel;
  logic [WAIT_W-1:0] nxtWait;
  logic [WAIT_W-1:0] curWait;
  logic        upper_lane_port_enable;

  // Upper lane port enable, and the settings that apply to the area of the access in flight.
  assign upper_lane_port_enable  = state_r.busControlTwo[UPPER_LANE_PORT_EN_BIT];
  assign curIs16 = state_r.req.area6 ? state_r.busControlTwo[AREA6_WIDTH16_BIT]
                                     : state_r.busControlTwo[AREA5_WIDTH16_BIT];
  // Lane drive and wait enable are registered together with the state they belong to.
  // They are therefore worked out from the request and byte phase of the coming cycle.
  // Using the current request instead would put the previous access's bytes on the lanes.
  assign startNow = (state_r.st == PCLP_IDLE) && accStart;
  assign nxtReq   = startNow ? accReq : state_r.req;
  assign nxtPhase = startNow ? 1'b0 : ((state_r.st == PCLP_GAP) ? 1'b1 : state_r.phase);
  assign nxtIs16  = nxtReq.area6 ? state_r.busControlTwo[AREA6_WIDTH16_BIT]
                                 : state_r.busControlTwo[AREA5_WIDTH16_BIT];
  assign nxtSel   = nxtReq.area6 ? state_r.busControlOne[AREA6_CARD_SELECT_BIT]
                                 : state_r.busControlOne[AREA5_CARD_SELECT_BIT];
  assign nxtWait  = nxtReq.area6
                  ? state_r.waitStateControlTwo[AREA6_WAIT_LSB +: WAIT_W]
                  : state_r.waitStateControlTwo[AREA5_WAIT_LSB +: WAIT_W];
  assign curWait = state_r.req.area6
                 ? state_r.waitStateControlTwo[AREA6_WAIT_LSB +: WAIT_W]
                 : state_r.waitStateControlTwo[AREA5_WAIT_LSB +: WAIT_W];

  pclp_lane_steer u_steer (
    .is16    (nxtIs16),
    .phase   (nxtPhase),
    .req     (nxtReq),
    .laneOut (steerOut),
    .laneOe  (steerOe)
  );

  // Register port, access sequencer and pin drive, all in one next-state process.
  always_comb begin
    state_nxt        = state_r;
    state_nxt.regAck = 1'b0;
    state_nxt.done   = 1'b0;

    // A write of the wrong width is dropped so a stray byte store cannot half-set a
    // control register; software is expected never to do it.
    if (regWrite && regSize == REG_SIZE_16) begin
      unique case (regAddr)
        BUS_CONTROL_ONE_ADDR:        state_nxt.busControlOne       = regWdata;
        BUS_CONTROL_TWO_ADDR:        state_nxt.busControlTwo       = regWdata;
        WAIT_STATE_CONTROL_TWO_ADDR: state_nxt.waitStateControlTwo = regWdata;
        PORT_CONTROL_REG_ADDR:       state_nxt.portControlReg      = regWdata;
        default: ;
      endcase
    end
    if (regWrite && regSize == REG_SIZE_8 && regAddr == PORT_DATA_REG_ADDR) begin
      state_nxt.portData = regWdata[7:0];
    end
    if (regWrite || regRead) begin
      state_nxt.regAck = 1'b1;
    end
    if (regRead) begin
      unique case (regAddr)
        BUS_CONTROL_ONE_ADDR:        state_nxt.regRdata = state_r.busControlOne;
        BUS_CONTROL_TWO_ADDR:        state_nxt.regRdata = state_r.busControlTwo;
        WAIT_STATE_CONTROL_TWO_ADDR: state_nxt.regRdata = state_r.waitStateControlTwo;
        PORT_CONTROL_REG_ADDR:       state_nxt.regRdata = state_r.portControlReg;
        // Output pins read back their latch, input pins read the line.
        PORT_DATA_REG_ADDR: state_nxt.regRdata = {8'h00,
          (state_r.portData & state_r.portControlReg[7:0]) |
          (dataIn[23:16] & ~state_r.portControlReg[7:0])};
        default:                     state_nxt.regRdata = 16'h0000;
      endcase
    end

    // Access sequencer: strobe lasts the wait setting plus one cycle, then the wait pin.
    unique case (state_r.st)
      PCLP_IDLE: begin
        if (accStart) begin
          state_nxt.req   = accReq;
          state_nxt.phase = 1'b0;
          state_nxt.cnt   = '0;
          state_nxt.st    = PCLP_STROBE;
        end
      end
      PCLP_STROBE: begin
        if (state_r.cnt != curWait) begin
          state_nxt.cnt = state_r.cnt + 1'b1;
        end else if (!(state_r.waitEnable && !cardWaitN)) begin
          // Read data lands per lane as the bus width dictates.
          if (!state_r.req.write) begin
            if (curIs16 && state_r.req.size != SIZE_BYTE) begin
              state_nxt.rdata = dataIn[15:0];
            end else if (curIs16) begin
              state_nxt.rdata = {8'h00, state_r.req.addr0 ? dataIn[7:0] : dataIn[15:8]};
            end else if (state_r.req.size == SIZE_BYTE) begin
              state_nxt.rdata = {8'h00, dataIn[7:0]};
            end else if (!state_r.phase) begin
              state_nxt.rdata[15:8] = dataIn[7:0];
            end else begin
              state_nxt.rdata[7:0] = dataIn[7:0];
            end
          end
          state_nxt.st = PCLP_GAP;
        end
      end
      PCLP_GAP: begin
        // A word on a narrow bus needs a second byte cycle for the odd address.
        if (!curIs16 && state_r.req.size != SIZE_BYTE && !state_r.phase) begin
          state_nxt.phase = 1'b1;
          state_nxt.cnt   = '0;
          state_nxt.st    = PCLP_STROBE;
        end else begin
          state_nxt.done = 1'b1;
          state_nxt.st   = PCLP_IDLE;
        end
      end
      default: state_nxt.st = PCLP_IDLE;
    endcase

    // Wait input only counts when the area has a nonzero wait setting.
    state_nxt.waitEnable = (state_nxt.st == PCLP_STROBE) && (nxtWait != '0);

    // Lower lanes follow the steering only while the strobe is active.
    state_nxt.lanes.out = 32'h0000_0000;
    state_nxt.lanes.oe  = 32'h0000_0000;
    if (state_nxt.st == PCLP_STROBE && nxtSel) begin
      state_nxt.lanes.out[15:0] = steerOut;
      state_nxt.lanes.oe[15:0]  = steerOe;
    end
    // Upper lanes: floating unless the port is enabled.
    if (upper_lane_port_enable) begin
      state_nxt.lanes.out[23:16] = state_nxt.portData;
      state_nxt.lanes.oe[23:16]  = state_nxt.portControlReg[7:0];
      state_nxt.lanes.out[31:30] =
        state_nxt.portControlReg[TOP_LANE_VALUE_LSB +: 2];
      state_nxt.lanes.oe[31:30]  = 2'b11;
    end

    // Strobes are driven high when idle and low in their area's access, or float.
    state_nxt.s5Oe  = state_nxt.busControlOne[AREA5_CARD_SELECT_BIT];
    state_nxt.s5Out = !(state_nxt.st == PCLP_STROBE && !state_nxt.req.area6);
    state_nxt.s6Oe  = state_nxt.busControlOne[AREA6_CARD_SELECT_BIT];
    state_nxt.s6Out = !(state_nxt.st == PCLP_STROBE && state_nxt.req.area6);
  end

  // Single register stage for all state; outputs come straight from it.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_r                     <= '0;
      state_r.busControlOne       <= BUS_CONTROL_ONE_RST;
      state_r.busControlTwo       <= BUS_CONTROL_TWO_RST;
      state_r.waitStateControlTwo <= WAIT_STATE_CONTROL_TWO_RST;
      state_r.portControlReg      <= PORT_CONTROL_REG_RST;
      state_r.portData            <= PORT_DATA_REG_RST;
      state_r.st                  <= PCLP_IDLE;
      state_r.s5Out               <= 1'b1;
      state_r.s6Out               <= 1'b1;
    end else begin
      state_r <= state_nxt;
    end
  end

  assign regRdata       = state_r.regRdata;
  assign regAck         = state_r.regAck;
  assign accRdata       = state_r.rdata;
  assign accDone        = state_r.done;
  assign lanes          = state_r.lanes;
  assign waitEnable     = state_r.waitEnable;
  assign area5StrobeOut = state_r.s5Out;
  assign area5StrobeOe  = state_r.s5Oe;
  assign area6StrobeOut = state_r.s6Out;
  assign area6StrobeOe  = state_r.s6Oe;

endmodule // pclp_card_ctrl

// file: verif/pclp_card_model.sv
// Behavioural PC card on the far side of the data lanes and strobes.
// Assumes active-low strobes and a testbench that sets the read value and stall.
module pclp_card_model
  import pclp_pkg::*;
(
  // Clock and controls from the testbench.
  input  wire logic        clk,
  input  wire logic        clr,
  input  wire logic [15:0] rdVal,
  input  wire logic [3:0]  stall,
  // Card pins.
  input  wire pclp_lanes_t lanes,
  input  wire logic        area5StrobeOut,
  input  wire logic        area6StrobeOut,
  output logic [31:0] dataIn,
  output logic        cardWaitN,
  // What the card saw.
  output logic [7:0]  hiSeen,
  output logic [15:0] byteLog,
  output logic [15:0] oeSeen
);
  logic        strobe;
  logic [3:0]  cnt = 4'h0;
  logic [31:0] last = 32'h0000_0000;
  assign strobe = !(area5StrobeOut && area6StrobeOut);
  // Wait is held low for the first stall cycles of each strobe.
  assign cardWaitN = !(strobe && cnt < stall);
  // Released lines show a pattern that changes every cycle, never a stale value.
  assign dataIn = strobe ? {16'h0000, rdVal} : ~last;
  // Capture lanes on the first cycle of each strobe.
  always_ff @(posedge clk) begin
    cnt  <= strobe ? cnt + 4'h1 : 4'h0;
    last <= dataIn;
    if (clr) begin
      oeSeen <= 16'h0000;
    end else if (strobe && cnt == 4'h0) begin
      hiSeen  <= lanes.out[15:8];
      byteLog <= {byteLog[7:0], lanes.out[7:0]};
      oeSeen  <= oeSeen | lanes.oe[15:0];
    end
  end
endmodule // pclp_card_model

// file: verif/pclp_card_ctrl_assertions.sv
// Concurrent checks on the pins of the card lane and pin control block.
// Assumes it is bound to the top module and sees only its ports.
module pclp_card_ctrl_assertions
  import pclp_pkg::*;
(
  // Clock, reset and register port.
  input wire logic        clk,
  input wire logic        rst,
  input wire logic        regWrite,
  input wire logic [31:0] regAddr,
  input wire logic [1:0]  regSize,
  input wire logic [15:0] regWdata,
  // Pins.
  input wire pclp_lanes_t lanes,
  input wire logic        accDone,
  input wire logic        waitEnable,
  input wire logic        area5StrobeOut,
  input wire logic        area6StrobeOut,
  input wire logic        area5StrobeOe,
  input wire logic        area6StrobeOe
);
  logic wr1, wr2, wrW, zeroWait_r, upper_lane_port_enable_r;
  // Only whole 16-bit writes count, as the block drops the rest.
  assign wr1 = regWrite && regAddr == BUS_CONTROL_ONE_ADDR && regSize == REG_SIZE_16;
  assign wr2 = regWrite && regAddr == BUS_CONTROL_TWO_ADDR && regSize == REG_SIZE_16;
  assign wrW = regWrite && regAddr == WAIT_STATE_CONTROL_TWO_ADDR && regSize == REG_SIZE_16;
  // Shadow of the fields that steer pins.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      zeroWait_r <= 1'b1;
      upper_lane_port_enable_r   <= 1'b0;
    end else begin
      if (wrW) zeroWait_r <= regWdata[6:4] == 3'h0 && regWdata[2:0] == 3'h0;
      if (wr2) upper_lane_port_enable_r <= regWdata[UPPER_LANE_PORT_EN_BIT];
    end
  end
  default clocking dc @(posedge clk); endclocking
  default disable iff (rst);
  a_a5_strobe_float: assert property (
    wr1 && !regWdata[AREA5_CARD_SELECT_BIT] |=> !area5StrobeOe)
    else $error("Area 5 strobe driven while deselected.");
  a_a6_strobe_float: assert property (
    wr1 && !regWdata[AREA6_CARD_SELECT_BIT] |=> !area6StrobeOe)
    else $error("Area 6 strobe driven while deselected.");
  a_wait_off: assert property (
    zeroWait_r && !$past(wrW) |-> !waitEnable)
    else $error("Wait input enabled with zero wait setting.");
  a_upper_float: assert property (
    !upper_lane_port_enable_r && !$past(wr2) |-> lanes.oe[31:16] == 16'h0000)
    else $error("Upper lanes driven with port disabled.");
  a_top_lanes: assert property (
    upper_lane_port_enable_r && !$past(wr2) |-> lanes.oe[31:24] == 8'hC0)
    else $error("Top lanes other than 31 and 30 driven.");
  a_lanes_strobe: assert property (
    lanes.oe[15:0] != 16'h0000 |-> !(area5StrobeOut && area6StrobeOut))
    else $error("Lower lanes driven outside a strobe.");
  a_done_pulse: assert property (accDone |=> !accDone)
    else $error("Access done held longer than one cycle.");
endmodule // pclp_card_ctrl_assertions
bind pclp_card_ctrl pclp_card_ctrl_assertions u_chk (.clk, .rst, .regWrite, .regAddr,
  .regSize, .regWdata, .lanes, .accDone, .waitEnable, .area5StrobeOut, .area6StrobeOut,
  .area5StrobeOe, .area6StrobeOe);

// file: verif/testbench.sv
// Self-checking bench for the card lane and pin control block with a card model.
// Assumes a 50 ns clock; inputs change on the falling edge.
module testbench
  import pclp_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 0, rst = 1, regWrite = 0, regRead = 0, accStart = 0, clr = 0;
  logic regAck, accDone, cardWaitN, waitEnable, a5o, a5e, a6o, a6e;
  logic [31:0] regAddr = 0, dataIn;
  logic [1:0]  regSize = 0;
  logic [15:0] regWdata = 0, regRdata, accRdata, byteLog, oeSeen, rdVal = 16'h5AC3;
  logic [7:0]  hiSeen;
  logic [3:0]  stall = 0;
  pclp_req_t   accReq = '0;
  logic [1:0]  accSize = SIZE_WORD;
  logic        accA0 = 1'b0;
  pclp_lanes_t lanes;
  int bad_count = 0, cmp_count = 0, cyc;
  always #25 clk = ~clk;
  pclp_card_ctrl dut (.clk, .rst, .regWrite, .regRead, .regAddr, .regSize, .regWdata,
    .regRdata, .regAck, .accStart, .accReq, .accRdata, .accDone, .dataIn, .lanes, .cardWaitN,
    .waitEnable, .area5StrobeOut(a5o), .area5StrobeOe(a5e), .area6StrobeOut(a6o),
    .area6StrobeOe(a6e));
  pclp_card_model card (.clk, .clr, .rdVal, .stall, .lanes, .area5StrobeOut(a5o),
    .area6StrobeOut(a6o), .dataIn, .cardWaitN, .hiSeen, .byteLog, .oeSeen);
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    cmp_count++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // One register cycle; the answer is looked at in the cycle after the strobe.
  task automatic rw(input logic w, input logic [31:0] a, input logic [1:0] s, input logic [15:0] d);
    @(negedge clk);
    {regWrite, regRead, regAddr, regSize, regWdata} = {w, !w, a, s, d};
    @(negedge clk);
    {regWrite, regRead} = 2'b00;
    chk(regAck, 1'b1);
    @(negedge clk);
  endtask
  task automatic rd(input logic [31:0] a, input logic [15:0] e);
    rw(1'b0, a, REG_SIZE_16, 16'h0000);
    chk(regRdata, e);
  endtask
  // One card access; cyc counts cycles from the request to done.
  task automatic acc(input logic a6, input logic w, input logic [15:0] d, input int e);
    @(negedge clk);
    {accReq, accStart, clr} = {a6, w, accSize, accA0, d, 2'b11};
    @(negedge clk);
    {accStart, clr} = 2'b00;
    for (cyc = 1; !accDone && cyc < 50; cyc++) @(negedge clk);
    chk(cyc, e);
  endtask
  task automatic complete_run;
    $display("Comparisons %0d, mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  initial begin
    repeat (20) @(posedge clk);
    @(negedge clk);
    rst = 0;
    rd(BUS_CONTROL_ONE_ADDR, BUS_CONTROL_ONE_RST);
    rd(BUS_CONTROL_TWO_ADDR, BUS_CONTROL_TWO_RST);
    rd(32'hffff_ff00, 16'h0000);
    chk({a5e, a6e, lanes.oe}, 34'h0);
    rw(1'b1, BUS_CONTROL_ONE_ADDR, REG_SIZE_16, 16'h0003);
    rw(1'b1, BUS_CONTROL_TWO_ADDR, REG_SIZE_16, 16'h0002);
    rw(1'b1, BUS_CONTROL_TWO_ADDR, REG_SIZE_8, 16'h0007);
    rd(BUS_CONTROL_TWO_ADDR, 16'h0002);
    chk({a5e, a6e}, 2'b11);
    acc(1'b0, 1'b1, 16'hA55A, 3);
    chk({hiSeen, byteLog[7:0]}, 16'hA55A);
    acc(1'b1, 1'b1, 16'h1234, 5);
    chk({byteLog, oeSeen[15:8]}, 24'h1234_00);
    acc(1'b1, 1'b0, 16'h0000, 5);
    chk(accRdata, 16'hC3C3);
    stall = 4'h3;
    acc(1'b0, 1'b0, 16'h0000, 3);
    chk(accRdata, rdVal);
    stall = 4'h0;
    // Byte accesses: odd byte read on the wide area, byte write on the narrow area.
    {accSize, accA0} = {SIZE_BYTE, 1'b1};
    acc(1'b0, 1'b0, 16'h0000, 3);
    chk(accRdata, 16'h00C3);
    acc(1'b1, 1'b1, 16'h0077, 3);
    chk({byteLog[7:0], oeSeen}, 24'h77_00FF);
    {accSize, accA0} = {SIZE_WORD, 1'b0};
    rw(1'b1, WAIT_STATE_CONTROL_TWO_ADDR, REG_SIZE_16, 16'h0002);
    acc(1'b0, 1'b0, 16'h0000, 5);
    // With a nonzero wait setting the card's wait stretches the strobe by two cycles.
    stall = 4'h4;
    acc(1'b0, 1'b0, 16'h0000, 7);
    stall = 4'h0;
    rw(1'b1, PORT_CONTROL_REG_ADDR, REG_SIZE_16, 16'hC0FF);
    rw(1'b1, PORT_DATA_REG_ADDR, REG_SIZE_8, 16'h00A5);
    rw(1'b1, BUS_CONTROL_TWO_ADDR, REG_SIZE_16, 16'h0003);
    chk({lanes.oe[31:16], lanes.out[31:30], lanes.out[23:16]}, 26'h303_FFA5);
    rw(1'b1, BUS_CONTROL_TWO_ADDR, REG_SIZE_16, 16'h0002);
    chk(lanes.oe[31:16], 16'h0000);
    rw(1'b1, BUS_CONTROL_ONE_ADDR, REG_SIZE_16, 16'h0000);
    chk({a5e, a6e}, 2'b00);
    complete_run();
  end
  // A run of about a hundred cycles ends long before this limit.
  initial begin
    #100000;
    bad_count++;
    complete_run();
  end
endmodule // testbench
